//--- papc_pkg.sv
package papc_pkg;

  // Operating modes of the device
  typedef enum logic [2:0] {
    PAPC_MODE_0 = 3'b000,
    PAPC_MODE_1 = 3'b001,
    PAPC_MODE_2 = 3'b010,
    PAPC_MODE_3 = 3'b011,
    PAPC_MODE_4 = 3'b100,
    PAPC_MODE_5 = 3'b101,
    PAPC_MODE_6 = 3'b110,
    PAPC_MODE_7 = 3'b111
  } papc_mode_e;

  // APB access phase of this slave
  typedef enum logic [1:0] {
    PAPC_APB_IDLE = 2'b00,
    PAPC_APB_SETUP = 2'b01,
    PAPC_APB_ACCESS = 2'b10
  } papc_apb_phase_e;

  localparam int PAPC_WIDTH = 8;
  localparam int PAPC_PIN_A20 = 7;
  localparam int PAPC_PIN_CMP_A = 6;

  // Printed offsets are register indices; byte address is four times the index
  localparam logic [19:0] PAPC_DIR_INDEX = 20'hEE009;
  localparam logic [19:0] PAPC_DATA_INDEX = 20'hFFFD9;
  localparam logic [31:0] PAPC_DIR_ADDR = {10'h000, PAPC_DIR_INDEX, 2'b00};
  localparam logic [31:0] PAPC_DATA_ADDR = {10'h000, PAPC_DATA_INDEX, 2'b00};

  localparam logic [7:0] PAPC_DIR_RST = 8'h00;
  localparam logic [7:0] PAPC_DATA_RST = 8'h00;
  localparam logic [7:0] PAPC_DIR_READ = 8'hFF;
  localparam logic [7:0] PAPC_ADDR_PIN_MASK = 8'h80;
  localparam logic [7:0] PAPC_ALL_INPUT = 8'hFF;
  localparam logic [23:0] PAPC_RDATA_PAD = 24'h000000;
  localparam logic [2:0] PAPC_IOCTL_OFF = 3'b000;
  localparam int PAPC_IOCTL_CAPT_BIT = 2;

  typedef struct packed {
    logic [31:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } papc_apb_req_s;

  // Channel 2 timer controls and compare outputs
  typedef struct packed {
    logic pwm_mode;
    logic [2:0] b_ioctl;
    logic [2:0] a_ioctl;
    logic cmp_b;
    logic cmp_a;
  } papc_tmr_ctl_s;

endpackage : papc_pkg

//--- papc_pin_sel.sv
`timescale 1ns/1ns
module papc_pin_sel (
  input wire logic addr_sel_i,  // Pin claimed as address output
  input wire logic addr_val_i,  // Address bit level
  input wire logic tmr_sel_i,   // Pin claimed as timer compare output
  input wire logic tmr_val_i,   // Timer compare level
  input wire logic dir_i,       // Direction bit, 1 = output
  input wire logic pat_en_i,    // Pattern output enable
  input wire logic pat_val_i,   // Pattern output level
  input wire logic port_val_i,  // Data register bit
  output logic drive_o,         // Pin is driven
  output logic val_o            // Level to drive
);

  always_comb begin
    drive_o = 1'b0;
    val_o = 1'b0;
    if (addr_sel_i) begin
      drive_o = 1'b1;
      val_o = addr_val_i;
    end else if (tmr_sel_i) begin
      drive_o = 1'b1;
      val_o = tmr_val_i;
    end else if (dir_i) begin
      drive_o = 1'b1;
      val_o = pat_en_i ? pat_val_i : port_val_i;
    end
  end

endmodule : papc_pin_sel

//--- papc_port.sv
`timescale 1ns/1ns
// Operation
// - Reset leaves pins input, except A20 modes 3/4; while reset is held pin 7 is input too, and drives from the first clock after
// - Direction 1 drives output, 0 is input
// - Direction register reads back all ones
// - Direction resets 0x00, or 0x80 in modes 3/4
// - Software standby keeps direction and driven outputs
// - General output pin drives data register bit
// - Port read mixes data and pin by direction
// - Data clears on reset, kept in software standby
// - Pin 7: compare B, else port or pattern
// - B control 001/01x selects output; 1xx captures
// - Pin 6: compare A, else port or pattern
// - PWM or A code 001/01x drives pin 6
// - Pins 3-0 same in all modes
// - Unclaimed pins are general input or output
// - Mode 5, enable low: pin 7 is A20
module papc_port
  import papc_pkg::*;
(
  input wire logic core_clk_i,                // System clock
  input wire logic resetn_i,                  // Asynchronous reset, active low
  input wire papc_apb_req_s apb_i,            // APB request
  output logic [31:0] prdata_o,               // APB read data
  output logic pready_o,                      // APB ready
  output logic pslverr_o,                     // APB error on unmapped address
  input wire papc_mode_e mode_i,              // Operating mode
  input wire logic hw_standby_i,              // Hardware standby
  input wire logic sw_standby_i,              // Software standby
  input wire papc_tmr_ctl_s tmr_i,            // Timer channel 2 controls
  input wire logic [7:0] pattern_enable_i,    // Pattern output enables
  input wire logic [7:0] pattern_out_i,       // Pattern output levels
  input wire logic addr20_enable_i,           // Mode 5 address 20 enable
  input wire logic addr20_i,                  // Address bit 20 level
  input wire logic [7:0] pin_i,               // Pin levels
  output logic [7:0] pin_o,                   // Pin output levels
  output logic [7:0] pin_oe_n_o,              // Pin output enables, low drives
  output logic capture_b_o,                   // Pin 7 level to capture B
  output logic capture_a_o                    // Pin 6 level to capture A
);

  papc_apb_phase_e phase;
  logic mode34;
  logic addr7_sel;
  logic tmr_b_sel;
  logic tmr_a_sel;
  logic cap_b_sel;
  logic cap_a_sel;
  logic wr_dir;
  logic wr_data;
  logic rd_setup;
  logic mapped;
  logic [7:0] dir_eff;
  logic [7:0] addr_sel_v;
  logic [7:0] addr_val_v;
  logic [7:0] tmr_sel_v;
  logic [7:0] tmr_val_v;
  logic [7:0] drive_v;
  logic [7:0] val_v;
  logic [7:0] dir_reg, dir_next;
  logic [7:0] data_reg, data_next;
  logic [31:0] prdata_reg, prdata_next;
  logic [7:0] pin_out_reg, pin_out_next;
  logic [7:0] pin_oe_n_reg, pin_oe_n_next;
  logic capture_b_reg, capture_b_next;
  logic capture_a_reg, capture_a_next;

  always_comb begin
    if (apb_i.psel && !apb_i.penable) begin
      phase = PAPC_APB_SETUP;
    end else if (apb_i.psel) begin
      phase = PAPC_APB_ACCESS;
    end else begin
      phase = PAPC_APB_IDLE;
    end
  end

  always_comb begin
    mapped = 1'b0;
    wr_dir = 1'b0;
    wr_data = 1'b0;
    if (apb_i.paddr == PAPC_DIR_ADDR) begin
      mapped = 1'b1;
      wr_dir = (phase == PAPC_APB_ACCESS) && apb_i.pwrite;
    end else if (apb_i.paddr == PAPC_DATA_ADDR) begin
      mapped = 1'b1;
      wr_data = (phase == PAPC_APB_ACCESS) && apb_i.pwrite;
    end
  end

  // Zero wait states: read data is captured in setup, ready in access
  assign pready_o = (phase == PAPC_APB_ACCESS);
  assign pslverr_o = (phase == PAPC_APB_ACCESS) && !mapped;
  assign rd_setup = (phase == PAPC_APB_SETUP) && !apb_i.pwrite;

  assign mode34 = (mode_i == PAPC_MODE_3) || (mode_i == PAPC_MODE_4);
  // Bit 7 is forced rather than stored, so the mode need not be caught at reset
  assign dir_eff = dir_reg | (mode34 ? PAPC_ADDR_PIN_MASK : PAPC_DIR_RST);

  // Register file; hardware standby clears like reset, software standby has no effect
  always_comb begin
    dir_next = dir_reg;
    data_next = data_reg;
    if (hw_standby_i) begin
      dir_next = PAPC_DIR_RST;
      data_next = PAPC_DATA_RST;
    end else begin
      if (wr_dir) begin
        dir_next = apb_i.pwdata[7:0];
        if (mode34) begin
          dir_next[PAPC_PIN_A20] = dir_reg[PAPC_PIN_A20];
        end
      end
      if (wr_data) begin
        data_next = apb_i.pwdata[7:0];
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dir_reg <= PAPC_DIR_RST;
      data_reg <= PAPC_DATA_RST;
    end else begin
      dir_reg <= dir_next;
      data_reg <= data_next;
    end
  end

  always_comb begin
    prdata_next = prdata_reg;
    if (rd_setup) begin
      if (apb_i.paddr == PAPC_DIR_ADDR) begin
        prdata_next = {PAPC_RDATA_PAD, PAPC_DIR_READ};
      end else if (apb_i.paddr == PAPC_DATA_ADDR) begin
        prdata_next = {PAPC_RDATA_PAD, (data_reg & dir_eff) | (pin_i & ~dir_eff)};
      end else begin
        prdata_next = {PAPC_RDATA_PAD, PAPC_DIR_RST};
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata_reg <= {PAPC_RDATA_PAD, PAPC_DIR_RST};
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  assign prdata_o = prdata_reg;

  // Channel 2 claims: B only by its code, A also by PWM
  assign tmr_b_sel = !tmr_i.b_ioctl[PAPC_IOCTL_CAPT_BIT] && (tmr_i.b_ioctl != PAPC_IOCTL_OFF);
  assign tmr_a_sel = tmr_i.pwm_mode
    || (!tmr_i.a_ioctl[PAPC_IOCTL_CAPT_BIT] && (tmr_i.a_ioctl != PAPC_IOCTL_OFF));
  assign cap_b_sel = tmr_i.b_ioctl[PAPC_IOCTL_CAPT_BIT] && !tmr_i.pwm_mode;
  assign cap_a_sel = tmr_i.a_ioctl[PAPC_IOCTL_CAPT_BIT] && !tmr_i.pwm_mode;
  assign addr7_sel = mode34 || ((mode_i == PAPC_MODE_5) && !addr20_enable_i);

  // Pins 5 to 0 carry no mode-dependent claim here, only port and pattern
  always_comb begin
    addr_sel_v = '0;
    addr_val_v = '0;
    tmr_sel_v = '0;
    tmr_val_v = '0;
    addr_sel_v[PAPC_PIN_A20] = addr7_sel;
    addr_val_v[PAPC_PIN_A20] = addr20_i;
    tmr_sel_v[PAPC_PIN_A20] = tmr_b_sel;
    tmr_val_v[PAPC_PIN_A20] = tmr_i.cmp_b;
    tmr_sel_v[PAPC_PIN_CMP_A] = tmr_a_sel;
    tmr_val_v[PAPC_PIN_CMP_A] = tmr_i.cmp_a;
  end

  for (genvar i = 0; i < PAPC_WIDTH; i++) begin : g_pin
    papc_pin_sel u_sel (
      .addr_sel_i(addr_sel_v[i]),
      .addr_val_i(addr_val_v[i]),
      .tmr_sel_i(tmr_sel_v[i]),
      .tmr_val_i(tmr_val_v[i]),
      .dir_i(dir_eff[i]),
      .pat_en_i(pattern_enable_i[i]),
      .pat_val_i(pattern_out_i[i]),
      .port_val_i(data_reg[i]),
      .drive_o(drive_v[i]),
      .val_o(val_v[i])
    );
  end

  always_comb begin
    pin_out_next = val_v;
    pin_oe_n_next = ~drive_v;
    if (hw_standby_i) begin
      pin_oe_n_next = PAPC_ALL_INPUT & ~(mode34 ? PAPC_ADDR_PIN_MASK : PAPC_DIR_RST);
    end
    capture_b_next = cap_b_sel && !addr7_sel && pin_i[PAPC_PIN_A20];
    capture_a_next = cap_a_sel && pin_i[PAPC_PIN_CMP_A];
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_out_reg <= PAPC_DATA_RST;
      pin_oe_n_reg <= PAPC_ALL_INPUT;
      capture_b_reg <= 1'b0;
      capture_a_reg <= 1'b0;
    end else begin
      pin_out_reg <= pin_out_next;
      pin_oe_n_reg <= pin_oe_n_next;
      capture_b_reg <= capture_b_next;
      capture_a_reg <= capture_a_next;
    end
  end

  assign pin_o = pin_out_reg;
  assign pin_oe_n_o = pin_oe_n_reg;
  assign capture_b_o = capture_b_reg;
  assign capture_a_o = capture_a_reg;

  sequence s_dir_write;
    wr_dir && !hw_standby_i && !mode34;
  endsequence

  sequence s_read_setup(logic [31:0] addr);
    rd_setup && (apb_i.paddr == addr);
  endsequence

  property p_dir_read_ones;
    @(posedge core_clk_i) disable iff (!resetn_i)
      s_read_setup(PAPC_DIR_ADDR) |=> pready_o && (prdata_o[7:0] == PAPC_DIR_READ);
  endproperty
  a_dir_read_ones: assert property (p_dir_read_ones) else $error("direction read not all ones");

  property p_dir_write;
    logic [7:0] wd;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (s_dir_write, wd = apb_i.pwdata[7:0]) |=> (dir_eff == wd);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write not stored");

  property p_mode34_bit7;
    @(posedge core_clk_i) disable iff (!resetn_i)
      mode34 && $past(resetn_i) |-> dir_eff[PAPC_PIN_A20] ##1 (!pin_oe_n_o[PAPC_PIN_A20] || !mode34);
  endproperty
  a_mode34_bit7: assert property (p_mode34_bit7) else $error("pin 7 not address in modes 3/4");

  property p_hw_standby_clear;
    @(posedge core_clk_i) disable iff (!resetn_i)
      hw_standby_i |=> (data_reg == PAPC_DATA_RST) && (dir_reg == PAPC_DIR_RST);
  endproperty
  a_hw_standby_clear: assert property (p_hw_standby_clear) else $error("standby did not clear");

  property p_sw_standby_keep;
    @(posedge core_clk_i) disable iff (!resetn_i)
      sw_standby_i && !hw_standby_i && !wr_data && !wr_dir |=> $stable(data_reg) && $stable(dir_reg);
  endproperty
  a_sw_standby_keep: assert property (p_sw_standby_keep) else $error("software standby lost state");

  property p_gpio_out;
    @(posedge core_clk_i) disable iff (!resetn_i)
      dir_eff[0] && !pattern_enable_i[0] && !hw_standby_i
      |=> !pin_oe_n_o[0] && (pin_o[0] == $past(data_reg[0]));
  endproperty
  a_gpio_out: assert property (p_gpio_out) else $error("pin 0 not driving data");

  property p_gpio_in;
    @(posedge core_clk_i) disable iff (!resetn_i)
      !dir_eff[5] |=> pin_oe_n_o[5];
  endproperty
  a_gpio_in: assert property (p_gpio_in) else $error("pin 5 driven while input");

  property p_port_read;
    logic [7:0] exp;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (s_read_setup(PAPC_DATA_ADDR), exp = (data_reg & dir_eff) | (pin_i & ~dir_eff))
      |=> pready_o && (prdata_o[7:0] == exp);
  endproperty
  a_port_read: assert property (p_port_read) else $error("port read mix wrong");

  property p_pin7_timer;
    @(posedge core_clk_i) disable iff (!resetn_i)
      tmr_b_sel && !addr7_sel && !hw_standby_i |=> !pin_oe_n_o[7] && (pin_o[7] == $past(tmr_i.cmp_b));
  endproperty
  a_pin7_timer: assert property (p_pin7_timer) else $error("pin 7 not compare B");

  property p_pin6_timer;
    @(posedge core_clk_i) disable iff (!resetn_i)
      tmr_i.pwm_mode && !hw_standby_i |=> !pin_oe_n_o[6] && (pin_o[6] == $past(tmr_i.cmp_a));
  endproperty
  a_pin6_timer: assert property (p_pin6_timer) else $error("pin 6 not compare A in PWM");

  property p_addr20;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (mode_i == PAPC_MODE_5) && !addr20_enable_i && !hw_standby_i
      |=> !pin_oe_n_o[7] && (pin_o[7] == $past(addr20_i));
  endproperty
  a_addr20: assert property (p_addr20) else $error("pin 7 not address in mode 5");

endmodule : papc_port

//--- papc_board_model.sv
`timescale 1ns/1ns
module papc_board_model (
  input wire logic [7:0] pin_o,      // Device drive levels
  input wire logic [7:0] pin_oe_n_o, // Device enables, low drives
  input wire logic [7:0] board_i,    // Board levels on undriven pins
  output logic [7:0] wire_o          // Resolved pin levels
);
  // An undriven pin follows the board, so a stale device level never shows
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      wire_o[b] = pin_oe_n_o[b] ? board_i[b] : pin_o[b];
    end
  end
endmodule : papc_board_model

//--- tb_port_a_pin_control.sv
`timescale 1ns/1ns
module tb_port_a_pin_control;
  import papc_pkg::*;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  papc_apb_req_s apb = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  papc_mode_e mode = PAPC_MODE_1;
  logic hw_sb = 1'b0;
  logic sw_sb = 1'b0;
  logic a20_en = 1'b1;
  logic a20 = 1'b0;
  papc_tmr_ctl_s tmr = '0;
  logic [7:0] pat_en = 8'h00;
  logic [7:0] pat_out = 8'h00;
  logic [7:0] board = 8'h00;
  logic [7:0] pin_w;
  logic [7:0] pin_o;
  logic [7:0] oe_n;
  logic cap_b;
  logic cap_a;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  logic [7:0] dir_m = 8'h00;
  logic [7:0] dat_m = 8'h00;
  logic [31:0] rd;
  logic err;

  always #4 core_clk_i = ~core_clk_i;

  papc_port uut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .apb_i(apb), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .mode_i(mode), .hw_standby_i(hw_sb), .sw_standby_i(sw_sb),
    .tmr_i(tmr), .pattern_enable_i(pat_en), .pattern_out_i(pat_out), .addr20_enable_i(a20_en),
    .addr20_i(a20), .pin_i(pin_w), .pin_o(pin_o), .pin_oe_n_o(oe_n), .capture_b_o(cap_b),
    .capture_a_o(cap_a));

  papc_board_model u_board (.pin_o(pin_o), .pin_oe_n_o(oe_n), .board_i(board), .wire_o(pin_w));

  task automatic print_verdict();
    $display("Counts: %0d checks, %0d mismatches", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic apb_xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk_i);
    apb.psel <= 1'b1;
    apb.penable <= 1'b0;
    apb.pwrite <= wr;
    apb.paddr <= addr;
    apb.pwdata <= wd;
    @(posedge core_clk_i);
    apb.penable <= 1'b1;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
    chk(n, 32'h1, "access cycles");
  endtask : apb_xfer

  function automatic logic m34();
    return mode == PAPC_MODE_3 || mode == PAPC_MODE_4;
  endfunction : m34

  // Model of pin selection, read-back and capture feed
  task automatic chk_pins();
    logic [7:0] oe;
    logic [7:0] val;
    logic [7:0] ed;
    logic a7;
    ed = m34() ? (dir_m | 8'h80) : dir_m;
    a7 = m34() || (mode == PAPC_MODE_5 && !a20_en);
    for (int b = 0; b < 8; b++) begin
      oe[b] = ~ed[b];
      val[b] = pat_en[b] ? pat_out[b] : dat_m[b];
    end
    if (tmr.b_ioctl inside {3'b001, 3'b010, 3'b011}) begin
      oe[7] = 1'b0;
      val[7] = tmr.cmp_b;
    end
    if (tmr.pwm_mode || tmr.a_ioctl inside {3'b001, 3'b010, 3'b011}) begin
      oe[6] = 1'b0;
      val[6] = tmr.cmp_a;
    end
    if (a7) begin
      oe[7] = 1'b0;
      val[7] = a20;
    end
    chk({24'h0, oe_n}, {24'h0, oe}, "enables");
    chk({24'h0, pin_o & ~oe}, {24'h0, val & ~oe}, "levels");
    chk({31'h0, cap_b}, {31'h0, !a7 && tmr.b_ioctl[2] && !tmr.pwm_mode && pin_w[7]}, "capb");
    chk({31'h0, cap_a}, {31'h0, tmr.a_ioctl[2] && !tmr.pwm_mode && pin_w[6]}, "capa");
    apb_xfer(1'b0, PAPC_DATA_ADDR, 32'h0);
    chk(rd, {24'h0, (ed & dat_m) | (~ed & pin_w)}, "port read");
  endtask : chk_pins

  initial begin
    logic [7:0] pe;
    logic [7:0] dw;
    void'($urandom(78));
    repeat (5) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    chk_pins();
    $display("Reset test done");
    for (int i = 0; i < 300; i++) begin
      pe = 8'($urandom);
      dw = 8'($urandom) | pe;
      @(posedge core_clk_i);
      mode <= papc_mode_e'(3'($urandom_range(1, 7)));
      tmr <= papc_tmr_ctl_s'(9'($urandom));
      pat_en <= pe;
      pat_out <= 8'($urandom);
      board <= 8'($urandom);
      a20_en <= 1'($urandom);
      a20 <= 1'($urandom);
      sw_sb <= 1'($urandom);
      @(posedge core_clk_i);
      apb_xfer(1'b1, PAPC_DIR_ADDR, {24'hABCDEF, dw});
      dir_m = m34() ? {dir_m[7], dw[6:0]} : dw;
      dw = 8'($urandom);
      apb_xfer(1'b1, PAPC_DATA_ADDR, {24'h0, dw});
      dat_m = dw;
      apb_xfer(1'b0, PAPC_DIR_ADDR, 32'h0);
      chk(rd, 32'h000000FF, "dir read");
      chk_pins();
    end
    $display("Random selection test done");
    apb_xfer(1'b1, 32'h00001000, 32'h5A);
    chk({31'h0, err}, 32'h1, "unmapped write err");
    apb_xfer(1'b0, 32'h00001000, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped read err");
    chk(rd, 32'h0, "unmapped read data");
    chk_pins();
    $display("Unmapped access test done");
    @(posedge core_clk_i);
    mode <= PAPC_MODE_3;
    tmr <= '0;
    pat_en <= 8'h00;
    hw_sb <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    chk({24'h0, oe_n}, 32'h7F, "standby enables");
    hw_sb <= 1'b0;
    dir_m = 8'h00;
    dat_m = 8'h00;
    repeat (2) @(posedge core_clk_i);
    chk_pins();
    $display("Hardware standby test done");
    apb_xfer(1'b1, PAPC_DATA_ADDR, 32'hC3);
    mode <= PAPC_MODE_4;
    resetn_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    chk({24'h0, oe_n}, 32'hFF, "reset enables");
    resetn_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    chk_pins();
    $display("Second reset test done");
    print_verdict();
  end
endmodule : tb_port_a_pin_control
